// [verilog/wds_top.sv]
// watchdog timer with sleep and wake control, apb register slave.
// assumes pclk at 100 MHz, a free-running watchdog oscillator on
// wdt_osc_clk (sampled, not a clock) and a core that pulses its
// instruction strobes for one pclk cycle.
//
// Behaviour
// R1 - watchdog counts its own free oscillator
// R2 - expiry while running gives full reset
// R3 - expiry while asleep wakes, no reset
// R4 - fuse clear disables watchdog completely
// R5 - base timeout 18 ms of oscillator
// R6 - prescaler assigned via owner bit, 1:128
// R7 - ratio field n divides by 2^n
// R8 - clear or sleep zero counter, prescaler
// R9 - any timeout clears expiry flag
// R10 - sleep entry clears, flags, halts oscillator, holds pins
// R11 - watchdog reset never drives reset pin
// R12 - wake on pin reset, watchdog, interrupt
// R13 - sleep flag set at powerup, cleared by sleep
// R14 - sleep prefetches next instruction
// R15 - wake needs own enable, ignores global
// R16 - global enable chooses vector after wake
// R17 - software puts nop after sleep
// R18 - pending enabled interrupt wakes at once
// R19 - every wake clears watchdog counter
// R20 - crystal modes wait 1024 periods after wake
`timescale 1ns/1ns
`include "wds_cfg.svh"
module wds_top import wds_pkg::*; #(
  parameter int OSC_HZ     = `WDS_OSC_HZ,      // watchdog oscillator rate
  parameter int OST_CYCLES = `WDS_OST_PERIODS  // start-up, main osc periods
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wdt_osc_clk,        // free rc oscillator level
  input  wire logic        main_osc_tick,      // one main-osc period pulse
  input  wire logic        watchdog_fuse_enable,
  input  wire logic        crystal_mode,       // crystal-type oscillator
  input  wire logic        clear_watchdog_instr,
  input  wire logic        sleep_instr,
  input  wire logic        global_irq_enable,
  input  wire logic [2:0]  irq_enable,         // edge, pin change, periph
  input  wire logic [2:0]  irq_flag,
  output logic             device_reset,       // internal reset pulse
  output logic             osc_driver_on,
  output logic             io_hold,
  output logic             core_resume,        // execute next instr pulse
  output logic             branch_to_vector,   // with resume: vector next
  output logic             prefetch_next,
  output logic             expiry_flag_n,
  output logic             sleep_flag_n
);
  // ==========================================================
  // constants
  // ==========================================================
  // the tick count is truncated, so a rate that does not divide evenly
  // times out slightly early; the 16-bit counter caps OSC_HZ near 3.6 MHz
  localparam int BASE_TICKS = (`WDS_TIMEOUT_MS * OSC_HZ) / 1000;
  localparam int CW = 16;
  localparam logic [CW-1:0] BASE_LAST = CW'(BASE_TICKS - 1);

  // ==========================================================
  // oscillator sampling and edge detect
  // ==========================================================
  // the rc level must stay put for at least two pclk cycles per phase,
  // or an edge is lost; pclk is far faster than any rc rate in use
  logic sync1_ff;       // first stage, read only by sync2_ff
  logic sync2_ff;
  logic osc_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff    <= 1'b0;
      sync2_ff    <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      sync1_ff    <= wdt_osc_clk;
      sync2_ff    <= sync1_ff;
      osc_prev_ff <= sync2_ff;
    end
  end
  // the rc edge keeps arriving during sleep, since pclk stands for the
  // always-on domain here; only the core's oscillator is stopped
  wire osc_tick = sync2_ff & ~osc_prev_ff;  // see R1

  // ==========================================================
  // registers and apb decode
  // ==========================================================
  logic [7:0] tcfg_ff;       // timer configuration
  logic       expiry_n_ff;
  logic       sleep_n_ff;
  wds_state_t state_ff;
  wds_state_t nxt_state;

  wire access   = psel & penable;
  wire hit_tcfg = paddr == `WDS_ADDR_TCFG;
  wire hit_ctrl = paddr == `WDS_ADDR_CTRL;
  wire hit_stat = paddr == `WDS_ADDR_STAT;
  wire mapped   = hit_tcfg | hit_ctrl | hit_stat;
  wire wr_tcfg  = access & pwrite & hit_tcfg;
  wire wr_ctrl  = access & pwrite & hit_ctrl;
  wire sw_clear = wr_ctrl & pwdata[`WDS_BIT_CLR];
  wire sw_sleep = wr_ctrl & pwdata[`WDS_BIT_SLEEP];

  // read mux; stat shows live state
  wire [31:0] rd_mux =
      hit_tcfg ? {24'h000000, tcfg_ff} :
      hit_stat ? {28'h0000000, state_ff == WDS_OST,
                  state_ff == WDS_SLEEP, sleep_n_ff, expiry_n_ff} :
      32'h00000000;

  // zero wait state slave; unmapped access errors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // writes are taken only at the completing edge (pready high)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tcfg_ff <= `WDS_TCFG_RST;
    else if (wr_tcfg & pready)
      tcfg_ff <= pwdata[7:0];  // see R6
  end

  // ==========================================================
  // prescaler and counter
  // ==========================================================
  wire       owner_wdt = tcfg_ff[`WDS_BIT_OWNER];  // see R6
  wire [2:0] ratio     = tcfg_ff[`WDS_RATIO_LSB +: 3];
  wire       do_clear  = clear_watchdog_instr | sleep_instr |
                         (sw_clear & pready) | (sw_sleep & pready);
  wire       enter_sleep = (sleep_instr | (sw_sleep & pready)) &&
                           state_ff == WDS_RUN;
  logic [6:0]    pre_ff;
  logic [CW-1:0] cnt_ff;
  logic          wake_clr;
  // ratio n selects 2^n; 1:1 when n = 0 or prescaler is elsewhere
  wire [6:0] pre_mask = owner_wdt ? 7'((8'h01 << ratio) - 8'h01) : 7'h00;
  wire pre_wrap  = (pre_ff & pre_mask) == pre_mask;  // see R7
  wire base_tick = osc_tick & pre_wrap;
  // wake_clr stays out of this term: it is decoded from timeout itself,
  // so feeding it back would close a combinational loop
  wire timeout   = watchdog_fuse_enable & base_tick &
                   (cnt_ff == BASE_LAST) & ~do_clear;  // see R4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 7'h00;
      cnt_ff <= '0;
    end else if (do_clear || wake_clr || !watchdog_fuse_enable) begin
      // prescaler only zeroed while it is ours
      pre_ff <= owner_wdt ? 7'h00 : pre_ff;  // see R8
      cnt_ff <= '0;                          // see R8, R19
    end else if (osc_tick) begin
      pre_ff <= 7'(pre_ff + 7'h01);
      if (base_tick)
        cnt_ff <= (cnt_ff == BASE_LAST) ? '0 : CW'(cnt_ff + 1'b1);  // see R5
    end
  end

  // ==========================================================
  // sleep state machine
  // ==========================================================
  wire irq_wake = |(irq_enable & irq_flag);  // see R15, R18
  logic [10:0] ost_ff;
  wire ost_done = ost_ff == 11'(OST_CYCLES - 1);

  always_comb begin
    nxt_state = state_ff;
    wake_clr  = 1'b0;
    case (state_ff)
      WDS_RUN: begin
        if (enter_sleep)
          nxt_state = WDS_SLEEP;  // see R10
      end
      WDS_SLEEP: begin
        if (timeout || irq_wake) begin  // see R3, R12
          wake_clr  = 1'b1;             // see R19
          nxt_state = crystal_mode ? WDS_OST : WDS_RUN;
        end
      end
      WDS_OST: begin
        if (main_osc_tick && ost_done)
          nxt_state = WDS_RUN;  // see R20
      end
      default: nxt_state = WDS_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state_ff <= WDS_RUN;
    else
      state_ff <= nxt_state;
  end

  // start-up timer counts main oscillator periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ost_ff <= 11'h000;
    else if (state_ff != WDS_OST)
      ost_ff <= 11'h000;
    else if (main_osc_tick)
      ost_ff <= 11'(ost_ff + 11'h001);  // see R20
  end

  // resume: on sleep exit without start-up, or end of start-up
  wire resume_now = (state_ff == WDS_SLEEP && nxt_state == WDS_RUN) ||
                    (state_ff == WDS_OST && nxt_state == WDS_RUN);
  logic wake_wdt_ff;   // remembers a watchdog wake across start-up

  // ==========================================================
  // flags and outputs
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expiry_n_ff <= 1'b1;   // power-up value
      sleep_n_ff  <= 1'b1;   // see R13
      wake_wdt_ff <= 1'b0;
    end else begin
      // timeout clearing wins over the sleep-entry set
      if (timeout)
        expiry_n_ff <= 1'b0;  // see R9
      else if (enter_sleep && watchdog_fuse_enable)
        expiry_n_ff <= 1'b1;  // see R10
      if (enter_sleep)
        sleep_n_ff <= 1'b0;   // see R13
      if (state_ff == WDS_SLEEP && wake_clr)
        wake_wdt_ff <= timeout;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset     <= 1'b0;
      osc_driver_on    <= 1'b1;
      io_hold          <= 1'b0;
      core_resume      <= 1'b0;
      branch_to_vector <= 1'b0;
      prefetch_next    <= 1'b0;
      expiry_flag_n    <= 1'b1;
      sleep_flag_n     <= 1'b1;
    end else begin
      // internal only: no reset-pin driver exists here
      device_reset     <= timeout && state_ff == WDS_RUN;  // see R2, R11
      osc_driver_on    <= nxt_state != WDS_SLEEP;          // see R10
      io_hold          <= nxt_state != WDS_RUN;            // see R10
      core_resume      <= resume_now;                      // see R16
      // a direct wake judges the live timeout, a delayed one the latch
      branch_to_vector <= resume_now & global_irq_enable &  // see R16
                          ~(state_ff == WDS_OST ? wake_wdt_ff : timeout);
      prefetch_next    <= enter_sleep;                     // see R14
      expiry_flag_n    <= timeout ? 1'b0 : expiry_n_ff;
      sleep_flag_n     <= enter_sleep ? 1'b0 : sleep_n_ff;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  a_fuse_blocks_reset: assert property (  // see R4
    @(posedge pclk) disable iff (!presetn)
    !watchdog_fuse_enable |=> !device_reset)
    else $error("reset while watchdog fuse clear");

  a_timeout_resets: assert property (  // see R2
    @(posedge pclk) disable iff (!presetn)
    timeout && state_ff == WDS_RUN |=> device_reset && !expiry_flag_n)
    else $error("run timeout without reset");

  a_sleep_no_reset: assert property (  // see R3
    @(posedge pclk) disable iff (!presetn)
    state_ff == WDS_SLEEP && timeout |=> !device_reset &&
      state_ff != WDS_SLEEP)
    else $error("sleep timeout mishandled");

  a_clear_zeroes: assert property (  // see R8
    @(posedge pclk) disable iff (!presetn)
    clear_watchdog_instr |=> cnt_ff == '0)
    else $error("counter not cleared");

  a_expiry_clears: assert property (  // see R9
    @(posedge pclk) disable iff (!presetn)
    timeout |=> !expiry_n_ff ##1 !expiry_flag_n)
    else $error("expiry flag not cleared");

  sequence s_enter;
    state_ff == WDS_RUN && enter_sleep;
  endsequence
  a_sleep_entry: assert property (  // see R10
    @(posedge pclk) disable iff (!presetn)
    s_enter and !timeout |=> !sleep_n_ff && !osc_driver_on && io_hold)
    else $error("sleep entry effects missing");

  a_irq_wakes: assert property (  // see R18
    @(posedge pclk) disable iff (!presetn)
    state_ff == WDS_SLEEP && irq_wake |=> state_ff != WDS_SLEEP &&
      cnt_ff == '0)
    else $error("enabled pending interrupt did not wake");

  a_prefetch: assert property (  // see R14
    @(posedge pclk) disable iff (!presetn)
    s_enter |=> prefetch_next)
    else $error("no prefetch on sleep");

  a_ost_wait: assert property (  // see R20
    @(posedge pclk) disable iff (!presetn)
    state_ff == WDS_OST && !(main_osc_tick && ost_done) |=> !core_resume)
    else $error("resumed before start-up wait");

  // ==========================================================
  // wake, flag, reset pulse and prescaler checks
  // ==========================================================
  // one cycle in sleep with a wake source present
  sequence s_wake;
    state_ff == WDS_SLEEP && (timeout || irq_wake);
  endsequence

  a_wake_zeroes: assert property (  // see R19
    @(posedge pclk) disable iff (!presetn)
    s_wake |=> cnt_ff == '0)
    else $error("counter not cleared on wake");

  a_crystal_waits: assert property (  // see R20
    @(posedge pclk) disable iff (!presetn)
    s_wake and crystal_mode |=> state_ff == WDS_OST && !core_resume)
    else $error("crystal wake skipped start-up wait");

  a_wdt_no_vector: assert property (  // see R16
    @(posedge pclk) disable iff (!presetn)
    state_ff == WDS_SLEEP && timeout |=> !branch_to_vector)
    else $error("watchdog wake branched to vector");

  a_irq_vector: assert property (  // see R16
    @(posedge pclk) disable iff (!presetn)
    state_ff == WDS_SLEEP && irq_wake && !timeout && !crystal_mode &&
      global_irq_enable |=> core_resume && branch_to_vector)
    else $error("interrupt wake did not take vector");

  a_needs_enable: assert property (  // see R15
    @(posedge pclk) disable iff (!presetn)
    state_ff == WDS_SLEEP && !irq_wake && !timeout |=>
      state_ff == WDS_SLEEP)
    else $error("woke without an enabled source");

  a_sleep_flag: assert property (  // see R13
    @(posedge pclk) disable iff (!presetn)
    enter_sleep |=> !sleep_flag_n && !sleep_n_ff)
    else $error("sleep flag not cleared by sleep");

  a_expiry_sets: assert property (  // see R10
    @(posedge pclk) disable iff (!presetn)
    enter_sleep && watchdog_fuse_enable && !timeout |=> expiry_n_ff)
    else $error("expiry flag not set on sleep entry");

  a_reset_pulse: assert property (  // see R2
    @(posedge pclk) disable iff (!presetn)
    device_reset |=> !device_reset)
    else $error("watchdog reset longer than one cycle");

  a_ratio_wrap: assert property (  // see R7
    @(posedge pclk) disable iff (!presetn)
    owner_wdt && ratio == 3'h7 && base_tick |-> pre_ff == 7'h7F)
    else $error("top prescaler ratio wrapped early");

  a_clear_prescaler: assert property (  // see R8
    @(posedge pclk) disable iff (!presetn)
    owner_wdt && clear_watchdog_instr |=> pre_ff == 7'h00)
    else $error("prescaler not cleared");
endmodule // wds_top

// [verilog/wds_cfg.svh]
// watchdog and sleep controller constants: offsets, fields, reset values,
// timing counts. included by the controller and the bench.
`ifndef WDS_CFG_SVH
`define WDS_CFG_SVH
// register indices (printed offset 81h is not a multiple of four)
`define WDS_IDX_TCFG      8'h81
`define WDS_IDX_CTRL      8'h82
`define WDS_IDX_STAT      8'h83
`define WDS_ADDR_TCFG     12'h204
`define WDS_ADDR_CTRL     12'h208
`define WDS_ADDR_STAT     12'h20C
`define WDS_TCFG_RST      8'hFF
// timer config field positions
`define WDS_BIT_OWNER     3
`define WDS_RATIO_LSB     0
// control register bits (write one = strobe)
`define WDS_BIT_CLR       0
`define WDS_BIT_SLEEP     1
// status register bit positions
`define WDS_ST_EXPIRY_N   0
`define WDS_ST_SLEEP_N    1
`define WDS_ST_ASLEEP     2
`define WDS_ST_STARTUP    3
// timing
`define WDS_TIMEOUT_MS    18
`define WDS_OSC_HZ        31250
`define WDS_OST_PERIODS   1024
`endif

// [verilog/wds_pkg.sv]
// types for the watchdog and sleep controller
package wds_pkg;
  typedef enum logic [1:0] {
    WDS_RUN   = 2'b00,
    WDS_SLEEP = 2'b01,
    WDS_OST   = 2'b11
  } wds_state_t;
endpackage

// [bench/wds_core_model.sv]
// core model for the watchdog and sleep controller: issues clear and
// sleep strobes and drives the interrupt enables and flags.
// assumes the bench calls its tasks and shares pclk with the block.
`timescale 1ns/1ns
module wds_core_model (
  input  wire logic       pclk,
  output logic            clear_watchdog_instr, // one-cycle strobe
  output logic            sleep_instr,          // one-cycle strobe
  output logic            global_irq_enable,    // level
  output logic [2:0]      irq_enable,           // per source enable
  output logic [2:0]      irq_flag              // per source request
);
  // ==========================================================
  // instruction issue
  // all lines start idle so the block sees no stray strobe
  initial begin
    clear_watchdog_instr = 1'b0;
    sleep_instr          = 1'b0;
    global_irq_enable    = 1'b0;
    irq_enable           = 3'h0;
    irq_flag             = 3'h0;
  end
  // strobe held exactly one cycle, as the core executes it once
  task do_clear;
    @(posedge pclk);
    clear_watchdog_instr <= 1'b1;
    @(posedge pclk);
    clear_watchdog_instr <= 1'b0;
  endtask
  // nothing else is issued in the slot after sleep, a plain no-op
  task do_sleep;
    @(posedge pclk);
    sleep_instr <= 1'b1;
    @(posedge pclk);
    sleep_instr <= 1'b0;
  endtask
  // interrupt sources change together on one edge
  task set_irq(input logic g, input logic [2:0] e, input logic [2:0] f);
    @(posedge pclk);
    global_irq_enable <= g;
    irq_enable        <= e;
    irq_flag          <= f;
  endtask
endmodule // wds_core_model

// [bench/wds_top_bench.sv]
// bench for the watchdog and sleep controller: apb tasks, timeout
// windows, sleep entry and wake sequences.
// assumes the core model file and the design package are compiled first.
`timescale 1ns/1ns
`include "wds_cfg.svh"
module wds_top_bench;
  // shortened oscillator rate: 18 base ticks, one tick per 4 cycles
  localparam int OSC = 1000;
  localparam int T0  = 18 * OSC / 1000 * 4;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr  = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        wdt_osc_clk = 0, main_osc_tick = 0;
  logic        watchdog_fuse_enable = 1, crystal_mode = 0;
  wire         clear_watchdog_instr, sleep_instr, global_irq_enable;
  wire  [2:0]  irq_enable, irq_flag;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, device_reset, osc_driver_on, io_hold;
  logic        core_resume, branch_to_vector, prefetch_next;
  logic        expiry_flag_n, sleep_flag_n, rs, cr, bv, err;
  int          n, failures = 0, n_compared = 0, cyc = 0;
  wds_top #(.OSC_HZ(OSC), .OST_CYCLES(4)) u_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .wdt_osc_clk, .main_osc_tick, .watchdog_fuse_enable, .crystal_mode,
    .clear_watchdog_instr, .sleep_instr, .global_irq_enable, .irq_enable,
    .irq_flag, .device_reset, .osc_driver_on, .io_hold, .core_resume,
    .branch_to_vector, .prefetch_next, .expiry_flag_n, .sleep_flag_n);
  wds_core_model u_core (.pclk, .clear_watchdog_instr, .sleep_instr,
    .global_irq_enable, .irq_enable, .irq_flag);
  // ==========================================================
  // clocks and hang guard
  always #5 pclk = ~pclk;
  // watchdog osc at a quarter of pclk, main osc tick every third cycle
  always @(posedge pclk) begin
    cyc           <= cyc + 1;
    wdt_osc_clk   <= cyc[1];
    main_osc_tick <= (cyc % 3 == 0);
    if (cyc == 30000) begin
      failures++;
      close_out();
    end
  end
  // ==========================================================
  // helpers
  task check(input string what, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
    end
  endtask
  // request held until pready is seen, read data taken with it
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    if (pready !== 1'b1)
      failures++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // counts cycles until a reset or a resume pulse, or the limit
  task wait_evt(input int lim);
    n  = 0;
    rs = 0;
    cr = 0;
    while (!rs && !cr && n < lim) begin
      @(negedge pclk);
      n++;
      rs = (device_reset === 1'b1);
      cr = (core_resume === 1'b1);
      bv = (branch_to_vector === 1'b1);
    end
  endtask
  task close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // test sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `WDS_ADDR_TCFG, 0); check("tcfg_rst", rd, 32'h0000_00FF);
    apb(0, `WDS_ADDR_STAT, 0); check("stat_rst", rd, 32'h3);
    apb(0, 12'h300, 0); check("unmapped", err, 1);
    apb(1, `WDS_ADDR_TCFG, 0);
    apb(0, `WDS_ADDR_TCFG, 0); check("tcfg_wr", rd, 0);
    // a second clear late in the period must restart the count
    u_core.do_clear();
    repeat (60) @(negedge pclk);
    u_core.do_clear();
    wait_evt(2000);
    check("run_reset", {rs, cr}, 2'b10);
    check("run_time", n >= T0 - 6 && n <= T0 + 10, 1);
    @(negedge pclk); check("expiry_run", expiry_flag_n, 0);
    // prescaler ratio, smallest step and the 1:128 end
    for (int r = 1; r < 8; r += 6) begin
      apb(1, `WDS_ADDR_TCFG, 32'h8 | r);
      apb(1, `WDS_ADDR_CTRL, 32'h1);
      wait_evt(12000);
      check("ratio", n >= (T0 << r) - 8 && n <= (T0 << r) + 10, 1);
    end
    apb(1, `WDS_ADDR_TCFG, 0);
    watchdog_fuse_enable <= 1'b0;
    u_core.do_clear();
    wait_evt(300); check("fuse_off", n, 300);
    @(posedge pclk);
    watchdog_fuse_enable <= 1'b1;
    // sleep entry, then watchdog wake with no reset
    u_core.do_sleep();
    @(negedge pclk);
    check("osc_off", osc_driver_on, 0);
    check("io_hold", io_hold, 1);
    check("prefetch", prefetch_next, 1);
    @(negedge pclk); check("sleep_n", sleep_flag_n, 0);
    apb(0, `WDS_ADDR_STAT, 0); check("stat_sleep", rd, 32'h5);
    wait_evt(2000);
    check("wdt_wake", {rs, cr, bv}, 3'b010);
    check("wake_time", n >= T0 - 16 && n <= T0 + 10, 1);
    check("osc_on", osc_driver_on, 1);
    check("io_free", io_hold, 0);
    @(negedge pclk); check("expiry_wake", expiry_flag_n, 0);
    // interrupt wake under both global enable settings
    for (int g = 0; g < 2; g++) begin
      u_core.set_irq(g[0], 3'b000, 3'b111);
      u_core.do_sleep();
      wait_evt(30); check("no_enable", n, 30);
      u_core.set_irq(g[0], 3'b100, 3'b111);
      wait_evt(20); check("irq_wake", {rs, cr, bv}, {2'b01, g[0]});
      u_core.set_irq(1'b0, 3'b000, 3'b000);
      wait_evt(200); check("wake_clr", rs && n >= T0 - 10, 1);
    end
    // a request already pending at sleep wakes at once
    u_core.set_irq(1'b0, 3'b010, 3'b010);
    u_core.do_sleep();
    wait_evt(10); check("pending", cr, 1);
    // crystal mode waits for main oscillator periods before resuming
    u_core.set_irq(1'b0, 3'b001, 3'b000);
    crystal_mode <= 1'b1;
    apb(1, `WDS_ADDR_CTRL, 32'h2);
    u_core.set_irq(1'b0, 3'b001, 3'b001);
    wait_evt(200); check("ost_wait", cr && n >= 9, 1);
    close_out();
  end
endmodule // wds_top_bench
